/* src/wsc_defines.svh */
// Constants for the waveform sequencer control block: register offsets,
// field positions, reset values and widths.
// Assumes inclusion by bare name from src/.
`ifndef WSC_DEFINES_SVH
`define WSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define WSC_ADDR_CTRL 4'h0
`define WSC_ADDR_START 4'h1
`define WSC_ADDR_COUNT 4'h2
`define WSC_ADDR_TRIGCFG 4'h3
`define WSC_ADDR_CMD 4'h4
`define WSC_ADDR_STATUS 4'h5
`define WSC_ADDR_TBL_IDX 4'h6
`define WSC_ADDR_TBL_LO 4'h7
`define WSC_ADDR_TBL_HI 4'h8
`define WSC_ADDR_POS 4'h9

// ----------------------------------------------------------------------------
// CTRL fields
// ----------------------------------------------------------------------------
`define WSC_CTRL_TRIG_LSB 0
`define WSC_CTRL_ARMED_BIT 2
`define WSC_CTRL_SEQMODE_LSB 3
`define WSC_CTRL_SEQOPT_BIT 5
`define WSC_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// TRIGCFG fields: per input, polarity invert then 2-bit edge select
// ----------------------------------------------------------------------------
`define WSC_TCFG_TRIG_LSB 0
`define WSC_TCFG_EVT_LSB 4
`define WSC_TCFG_EN_LSB 8

// ----------------------------------------------------------------------------
// CMD bits (self clearing strobes)
// ----------------------------------------------------------------------------
`define WSC_CMD_RUN_BIT 0
`define WSC_CMD_STOP_BIT 1
`define WSC_CMD_TRIG_BIT 2
`define WSC_CMD_EVT_BIT 3
`define WSC_CMD_EN_BIT 4

// ----------------------------------------------------------------------------
// Table entry layout (54 bits; the low 48 are written as LO and HI words, the top 6 load as zero)
// ----------------------------------------------------------------------------
`define WSC_TBL_DEPTH 16
`define WSC_IDX_W 4
`define WSC_ADDR_W 12
`define WSC_LEN_W 12
`define WSC_LOOP_W 8
`define WSC_GRAN 4
`define WSC_SAMPLE_W 14
`define WSC_MIN_LEN 12'h005

// Sample clock divisors for the sequencer clock (documentation only: this
// block already runs on the sequencer clock)
`define WSC_DIV_14BIT 48
`define WSC_DIV_12BIT 64
`define WSC_DIV_INTERP_BASE 24

`endif

/* src/wsc_edge_detect.sv */
// Edge detector for one trigger-type input on the sequencer clock.
// Input is already synchronous to clk_in; selectable polarity and edge.
`timescale 1ns/1ps
`include "wsc_defines.svh"

module wsc_edge_detect
  import wsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sig_in,
  input wire logic invert_in,
  input wire logic [1:0] edge_sel_in,
  output logic level_out,
  output logic pulse_out
);

  typedef struct packed {
    logic prev;
    logic cur;
  } wsc_edge_s;

  wsc_edge_s state_reg;
  wsc_edge_s state_next;

  always_comb begin
    state_next.prev = state_reg.cur;
    state_next.cur = sig_in ^ invert_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // 00 rising, 01 falling, 1x both
  always_comb begin
    level_out = state_reg.cur;
    case (edge_sel_in)
      2'h0: pulse_out = state_reg.cur & ~state_reg.prev;
      2'h1: pulse_out = ~state_reg.cur & state_reg.prev;
      default: pulse_out = state_reg.cur ^ state_reg.prev;
    endcase
  end

endmodule : wsc_edge_detect

/* src/wsc_pkg.sv */
// Types shared by the waveform sequencer control block.
// Constants live in wsc_defines.svh.
package wsc_pkg;

  typedef enum logic [1:0] {
    WSC_TRIG_CONT = 2'h0,
    WSC_TRIG_TRIGGERED = 2'h1,
    WSC_TRIG_GATED = 2'h2
  } wsc_trig_e;

  typedef enum logic [1:0] {
    WSC_ADV_AUTO = 2'h0,
    WSC_ADV_COND = 2'h1,
    WSC_ADV_REPEAT = 2'h2,
    WSC_ADV_SINGLE = 2'h3
  } wsc_adv_e;

  typedef enum logic [1:0] {
    WSC_SEQ_ARB = 2'h0,
    WSC_SEQ_SEQUENCE = 2'h1,
    WSC_SEQ_SCENARIO = 2'h2
  } wsc_seqmode_e;

  typedef enum logic [4:0] {
    WSC_ST_PROG = 5'h01,
    WSC_ST_WAIT = 5'h02,
    WSC_ST_PLAY = 5'h04,
    WSC_ST_HOLD = 5'h08,
    WSC_ST_PAUSE = 5'h10
  } wsc_state_e;

  // One table entry: sample memory reference, length, loops, advancement,
  // marker bits for loop end and end of a sequence.
  typedef struct packed {
    logic [11:0] addr;
    logic [11:0] len;
    logic [7:0] loops;
    logic [1:0] adv;
    logic seq_end;
    logic loop_end;
    logic [3:0] loop_start;
    logic [7:0] seq_loops;
    logic [5:0] spare;
  } wsc_entry_s;

endpackage : wsc_pkg

/* src/wsc_sample_addr.sv */
// Address generator: turns an entry's sample-memory base and the position
// inside the segment into one address per sample of the group.
// Assumes the sample memory answers one cycle later outside this block.
`timescale 1ns/1ps
`include "wsc_defines.svh"

module wsc_sample_addr
  import wsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic play_in,
  input wire logic [`WSC_ADDR_W-1:0] base_in,
  input wire logic [`WSC_LEN_W-1:0] pos_in,
  output logic [`WSC_GRAN*`WSC_ADDR_W-1:0] addr_out,
  output logic valid_out
);

  typedef struct packed {
    logic [`WSC_GRAN*`WSC_ADDR_W-1:0] addr;
    logic valid;
  } wsc_addr_s;

  wsc_addr_s state_reg;
  wsc_addr_s state_next;
  logic [`WSC_GRAN*`WSC_ADDR_W-1:0] lane_addr;

  // Base plus group offset, so any entry may share the same memory region
  genvar g;
  generate
    for (g = 0; g < `WSC_GRAN; g++) begin : gen_lane
      assign lane_addr[g*`WSC_ADDR_W +: `WSC_ADDR_W] =
        `WSC_ADDR_W'(base_in + `WSC_ADDR_W'(pos_in) * `WSC_ADDR_W'(`WSC_GRAN) + `WSC_ADDR_W'(g));
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.valid = play_in;
    if (play_in) begin
      state_next.addr = lane_addr;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign addr_out = state_reg.addr;
  assign valid_out = state_reg.valid;

endmodule : wsc_sample_addr

/* src/wsc_sequencer.sv */
// Waveform sequencer control: table of sequence vectors, trigger/arm/advance
// control, and the per-cycle sample group address toward the datapath.
// Assumes clk_in is the sequencer clock and external inputs are synchronous.
`timescale 1ns/1ps
`include "wsc_defines.svh"

module wsc_sequencer
  import wsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic trigger_in,
  input wire logic event_in,
  input wire logic enable_in,
  output logic [`WSC_GRAN*`WSC_ADDR_W-1:0] sample_addr_out,
  output logic sample_valid_out,
  output logic hold_last_out,
  output logic running_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    wsc_state_e st;
    logic [31:0] ctrl;
    logic [`WSC_IDX_W-1:0] start_ptr;
    logic [15:0] top_count;
    logic [11:0] tcfg;
    logic [`WSC_IDX_W-1:0] tbl_idx;
    logic [31:0] tbl_lo;
    logic [`WSC_IDX_W-1:0] cur;
    logic [`WSC_LEN_W-1:0] pos;
    logic [7:0] loop_cnt;
    logic [7:0] jump_cnt;
    logic [7:0] seq_cnt;
    logic [15:0] top_cnt;
    logic evt_pend;
    logic evt_seen;
    logic armed_hold;
    logic [31:0] rdata;
  } wsc_state_s;

  wsc_state_s state_reg;
  wsc_state_s state_next;
  wsc_entry_s table_reg [`WSC_TBL_DEPTH];
  wsc_entry_s entry;
  logic trig_pulse, evt_pulse, en_pulse, gate_level, en_level;
  logic cmd_wr;
  logic cmd_run, cmd_stop, cmd_trig, cmd_evt, cmd_en;
  wsc_trig_e trig_mode;
  logic armed, seq_opt, standalone;
  logic seg_end, play_now;
  logic [`WSC_IDX_W-1:0] next_idx;

  // --------------------------------------------------------------------------
  // Input edge detection on the sequencer clock
  // --------------------------------------------------------------------------
  wsc_edge_detect u_trig (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sig_in(trigger_in),
    .invert_in(state_reg.tcfg[`WSC_TCFG_TRIG_LSB]),
    .edge_sel_in(state_reg.tcfg[`WSC_TCFG_TRIG_LSB+1 +: 2]),
    .level_out(gate_level),
    .pulse_out(trig_pulse)
  );

  wsc_edge_detect u_evt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sig_in(event_in),
    .invert_in(state_reg.tcfg[`WSC_TCFG_EVT_LSB]),
    .edge_sel_in(state_reg.tcfg[`WSC_TCFG_EVT_LSB+1 +: 2]),
    .level_out(),
    .pulse_out(evt_pulse)
  );

  wsc_edge_detect u_en (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sig_in(enable_in),
    .invert_in(state_reg.tcfg[`WSC_TCFG_EN_LSB]),
    .edge_sel_in(state_reg.tcfg[`WSC_TCFG_EN_LSB+1 +: 2]),
    .level_out(en_level),
    .pulse_out(en_pulse)
  );

  // --------------------------------------------------------------------------
  // Decode of configuration and command strobes
  // --------------------------------------------------------------------------
  assign cmd_wr = reg_wr_in && (reg_addr_in == `WSC_ADDR_CMD);
  assign cmd_run = cmd_wr && reg_wdata_in[`WSC_CMD_RUN_BIT];
  assign cmd_stop = cmd_wr && reg_wdata_in[`WSC_CMD_STOP_BIT];
  // Software strobes are ored with the external inputs
  assign cmd_trig = (cmd_wr && reg_wdata_in[`WSC_CMD_TRIG_BIT]) || trig_pulse;
  assign cmd_evt = (cmd_wr && reg_wdata_in[`WSC_CMD_EVT_BIT]) || evt_pulse;
  assign cmd_en = (cmd_wr && reg_wdata_in[`WSC_CMD_EN_BIT]) || en_pulse;

  assign seq_opt = state_reg.ctrl[`WSC_CTRL_SEQOPT_BIT];
  // Without the option, force self-armed single-segment arbitrary play
  assign trig_mode = wsc_trig_e'(state_reg.ctrl[`WSC_CTRL_TRIG_LSB +: 2]);
  assign armed = state_reg.ctrl[`WSC_CTRL_ARMED_BIT] && seq_opt;
  assign standalone = !seq_opt ||
    (state_reg.ctrl[`WSC_CTRL_SEQMODE_LSB +: 2] == WSC_SEQ_ARB);

  assign entry = table_reg[state_reg.cur];
  assign seg_end = (state_reg.pos == entry.len - `WSC_LEN_W'(1));
  assign play_now = (state_reg.st == WSC_ST_PLAY);

  // --------------------------------------------------------------------------
  // Table storage
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `WSC_TBL_DEPTH; i++) begin
        table_reg[i] <= '0;
      end
    end else if (reg_wr_in && reg_addr_in == `WSC_ADDR_TBL_HI && state_reg.st == WSC_ST_PROG) begin
      table_reg[state_reg.tbl_idx] <= wsc_entry_s'({6'h00, reg_wdata_in[15:0], state_reg.tbl_lo});
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer engine and register file
  // --------------------------------------------------------------------------
  always_comb begin
    logic elem_done, last_loop, use_evt, top_done;
    elem_done = 1'b0;
    last_loop = 1'b0;
    use_evt = 1'b0;
    top_done = 1'b0;
    next_idx = `WSC_IDX_W'(state_reg.cur + `WSC_IDX_W'(1));
    state_next = state_reg;

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        `WSC_ADDR_CTRL: state_next.ctrl = reg_wdata_in;
        `WSC_ADDR_START: state_next.start_ptr = reg_wdata_in[`WSC_IDX_W-1:0];
        `WSC_ADDR_COUNT: state_next.top_count = reg_wdata_in[15:0];
        `WSC_ADDR_TRIGCFG: state_next.tcfg = reg_wdata_in[11:0];
        `WSC_ADDR_TBL_IDX: state_next.tbl_idx = reg_wdata_in[`WSC_IDX_W-1:0];
        `WSC_ADDR_TBL_LO: state_next.tbl_lo = reg_wdata_in;
        default: ;
      endcase
    end

    // Event latch: set wins over the consume-clear below
    if (cmd_evt && state_reg.st != WSC_ST_PROG) begin
      state_next.evt_pend = 1'b1;
    end

    case (state_reg.st)
      WSC_ST_PROG: begin
        if (cmd_run) begin
          state_next.cur = state_reg.start_ptr;
          state_next.pos = '0;
          state_next.loop_cnt = '0;
          state_next.jump_cnt = '0;
          state_next.seq_cnt = '0;
          state_next.top_cnt = '0;
          state_next.evt_pend = 1'b0;
          state_next.armed_hold = armed && trig_mode == WSC_TRIG_CONT && !standalone;
          state_next.st = (trig_mode == WSC_TRIG_CONT && !(armed && standalone)) ?
            WSC_ST_PLAY : WSC_ST_WAIT;
        end
      end
      WSC_ST_WAIT: begin
        // Armed waits for enable level as an extra start condition
        if (!armed || en_level || cmd_en) begin
          case (trig_mode)
            WSC_TRIG_TRIGGERED: if (cmd_trig) state_next.st = WSC_ST_PLAY;
            WSC_TRIG_GATED: if (trig_pulse && gate_level) state_next.st = WSC_ST_PLAY;
            default: state_next.st = WSC_ST_PLAY;
          endcase
        end
      end
      WSC_ST_PAUSE: begin
        if (trig_pulse && gate_level) begin
          state_next.st = WSC_ST_PLAY;
        end
      end
      WSC_ST_PLAY: begin
        // Triggers while playing fall through unused
        if (trig_mode == WSC_TRIG_GATED && !gate_level) begin
          state_next.st = WSC_ST_PAUSE;
        end else if (!seg_end) begin
          state_next.pos = `WSC_LEN_W'(state_reg.pos + `WSC_LEN_W'(1));
        end else begin
          state_next.pos = '0;
          last_loop = (state_reg.loop_cnt + 8'h01 >= entry.loops);
          if (state_reg.armed_hold) begin
            // First element loops until an enable edge
            if (cmd_en) begin
              state_next.armed_hold = 1'b0;
              elem_done = 1'b1;
            end
          end else begin
            case (wsc_adv_e'(entry.adv))
              WSC_ADV_COND: begin
                if (state_reg.evt_pend) begin
                  use_evt = 1'b1;
                  elem_done = 1'b1;
                end
              end
              WSC_ADV_REPEAT: begin
                if (last_loop) begin
                  state_next.st = WSC_ST_HOLD;
                end else begin
                  state_next.loop_cnt = state_reg.loop_cnt + 8'h01;
                end
              end
              WSC_ADV_SINGLE: begin
                state_next.st = WSC_ST_HOLD;
              end
              default: begin
                if (last_loop) begin
                  elem_done = 1'b1;
                end else begin
                  state_next.loop_cnt = state_reg.loop_cnt + 8'h01;
                end
              end
            endcase
          end
        end
      end
      WSC_ST_HOLD: begin
        // Last sample is held; an early event waited here until now
        if (state_reg.evt_pend) begin
          use_evt = 1'b1;
          state_next.st = WSC_ST_PLAY;
          if (wsc_adv_e'(entry.adv) == WSC_ADV_SINGLE &&
              state_reg.loop_cnt + 8'h01 < entry.loops) begin
            state_next.loop_cnt = state_reg.loop_cnt + 8'h01;
          end else begin
            elem_done = 1'b1;
          end
        end
      end
      default: state_next.st = WSC_ST_PROG;
    endcase

    if (use_evt) begin
      state_next.evt_pend = cmd_evt;
    end

    // Element complete: walk the table and the loop hierarchy
    if (elem_done) begin
      state_next.loop_cnt = '0;
      if (standalone) begin
        top_done = 1'b1;
      end else if (entry.loop_end && state_reg.jump_cnt + 8'h01 < entry.seq_loops) begin
        state_next.jump_cnt = state_reg.jump_cnt + 8'h01;
        state_next.cur = entry.loop_start;
      end else if (entry.seq_end) begin
        state_next.jump_cnt = '0;
        // Top-level repeat: zero count means forever
        if (state_reg.top_count == 16'h0000 || state_reg.top_cnt + 16'h0001 < state_reg.top_count) begin
          state_next.top_cnt = state_reg.top_cnt + 16'h0001;
          state_next.cur = state_reg.start_ptr;
        end else begin
          top_done = 1'b1;
        end
      end else begin
        state_next.jump_cnt = entry.loop_end ? 8'h00 : state_reg.jump_cnt;
        state_next.cur = seq_opt ? next_idx : state_reg.cur;
      end
    end

    if (top_done) begin
      state_next.cur = state_reg.start_ptr;
      state_next.top_cnt = '0;
      if (trig_mode == WSC_TRIG_CONT) begin
        state_next.st = WSC_ST_PLAY;
      end else begin
        state_next.st = WSC_ST_WAIT;
      end
    end

    if (cmd_stop) begin
      state_next.st = WSC_ST_PROG;
      state_next.evt_pend = 1'b0;
    end

    // Read data for the next cycle
    case (reg_addr_in)
      `WSC_ADDR_CTRL: state_next.rdata = state_reg.ctrl;
      `WSC_ADDR_START: state_next.rdata = 32'(state_reg.start_ptr);
      `WSC_ADDR_COUNT: state_next.rdata = 32'(state_reg.top_count);
      `WSC_ADDR_TRIGCFG: state_next.rdata = 32'(state_reg.tcfg);
      `WSC_ADDR_STATUS: state_next.rdata = {25'h0, state_reg.evt_pend, state_reg.armed_hold, state_reg.st};
      `WSC_ADDR_TBL_IDX: state_next.rdata = 32'(state_reg.tbl_idx);
      `WSC_ADDR_TBL_LO: state_next.rdata = state_reg.tbl_lo;
      `WSC_ADDR_POS: state_next.rdata = {4'h0, state_reg.pos, 8'h00, state_reg.loop_cnt};
      default: state_next.rdata = 32'h0000_0000;
    endcase
    if (!reg_rd_in) begin
      state_next.rdata = 32'h0000_0000;
    end
    state_next.rdata = state_next.rdata | (reg_rd_in && reg_addr_in == `WSC_ADDR_STATUS ?
      32'(state_reg.cur) << 8 : 32'h0000_0000);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '{st: WSC_ST_PROG, ctrl: `WSC_CTRL_RESET, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Sample group output
  // --------------------------------------------------------------------------
  wsc_sample_addr u_addr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .play_in(play_now),
    .base_in(entry.addr),
    .pos_in(state_reg.pos),
    .addr_out(sample_addr_out),
    .valid_out(sample_valid_out)
  );

  assign reg_rdata_out = state_reg.rdata;
  assign hold_last_out = (state_reg.st == WSC_ST_HOLD);
  assign running_out = (state_reg.st != WSC_ST_PROG);

endmodule : wsc_sequencer

/* tb/waveform_sequencer_control_test.sv */
// Self-checking bench for wsc_sequencer: registers, trigger edges, runs.
// Assumes package, design, source model and checker compiled first.
`timescale 1ns/1ps
`include "wsc_defines.svh"
module waveform_sequencer_control_test
  import wsc_pkg::*;
();
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic trig_lvl = 1'b0;
  logic evt_lvl = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [31:0] v;
  logic [`WSC_GRAN*`WSC_ADDR_W-1:0] sample_addr_out;
  logic trigger_in, event_in, enable_in, sample_valid_out, hold_last_out, running_out;
  int bad_count = 0;
  int samples_checked = 0;
  int n = 0;
  // Rows: {trigger config, state expected after a pin rise}
  logic [8:0] rows [5] = '{9'h004, 9'h042, 9'h084, 9'h022, 9'h064};
  always #12.5 clk_in = ~clk_in;
  always @(negedge clk_in) n += (sample_valid_out === 1'b1);
  wsc_src_model src (.clk_in(clk_in), .trig_req_in(trig_lvl), .evt_req_in(evt_lvl), .en_req_in(1'b0),
    .trigger_out(trigger_in), .event_out(event_in), .enable_out(enable_in));
  wsc_sequencer dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .trigger_in(trigger_in), .event_in(event_in),
    .enable_in(enable_in), .sample_addr_out(sample_addr_out), .sample_valid_out(sample_valid_out),
    .hold_last_out(hold_last_out), .running_out(running_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge clk_in);
  endtask : rd
  task automatic tbl(input logic [3:0] i, input logic [47:0] e);
    wr(`WSC_ADDR_TBL_IDX, {28'h0, i});
    wr(`WSC_ADDR_TBL_LO, e[31:0]);
    wr(`WSC_ADDR_TBL_HI, {16'h0, e[47:32]});
  endtask : tbl
  task automatic summarize();
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4000) @(posedge clk_in);
    bad_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1 check({29'h0, running_out, hold_last_out, sample_valid_out}, 32'h0);
    @(posedge clk_in);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h7f, 32'h1);
    rd(`WSC_ADDR_CTRL, v);
    check(v, `WSC_CTRL_RESET);
    rd(4'hf, v);
    check(v, 32'h0);
    $display("reset test done");
    // Both entries point at one sample region; lengths are whole groups
    tbl(4'h0, {6'h01, 12'h100, 8'h01, 2'h0, 20'h0});
    tbl(4'h1, {6'h01, 12'h040, 8'h01, 2'h0, 20'h0});
    wr(`WSC_ADDR_COUNT, 32'h1);
    wr(`WSC_ADDR_CTRL, 32'(WSC_TRIG_TRIGGERED));
    foreach (rows[i]) begin
      wr(`WSC_ADDR_TRIGCFG, {28'h0, rows[i][8:5]});
      wr(`WSC_ADDR_CMD, 32'h1);
      repeat (3) @(posedge clk_in);
      trig_lvl <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(`WSC_ADDR_STATUS, v);
      check(v & 32'h1f, {27'h0, rows[i][4:0]});
      wr(`WSC_ADDR_CMD, 32'h2);
      trig_lvl <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    $display("edge table done");
    // Second rise lands mid-play and must not start another pass
    wr(`WSC_ADDR_TRIGCFG, 32'h0);
    wr(`WSC_ADDR_START, 32'h1);
    wr(`WSC_ADDR_CMD, 32'h1);
    n = 0;
    trig_lvl <= 1'b1;
    repeat (4) @(posedge clk_in);
    trig_lvl <= 1'b0;
    repeat (4) @(posedge clk_in);
    trig_lvl <= 1'b1;
    repeat (70) @(posedge clk_in);
    check(n, 32'd64);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h1f, 32'h2);
    wr(`WSC_ADDR_CMD, 32'h2);
    $display("triggered test done");
    wr(`WSC_ADDR_CTRL, 32'(WSC_TRIG_CONT));
    n = 0;
    wr(`WSC_ADDR_CMD, 32'h1);
    repeat (38) @(posedge clk_in);
    check(n, 32'd38);
    wr(`WSC_ADDR_CMD, 32'h2);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h1f, 32'h1);
    $display("continuous test done");
    // Repeat advancement: two loops of an 8-group entry, then hold until an event pin rise
    tbl(4'h2, {6'h03, 12'h008, 8'h02, 2'h2, 20'h0});
    wr(`WSC_ADDR_START, 32'h2);
    wr(`WSC_ADDR_CMD, 32'h1);
    n = 0;
    repeat (24) @(posedge clk_in);
    #1 check({31'h0, hold_last_out}, 32'h1);
    check(n, 32'd16);
    check({20'h0, sample_addr_out[11:0]}, 32'h0000_001f);
    @(posedge clk_in);
    evt_lvl <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h7f, 32'h4);
    wr(`WSC_ADDR_CMD, 32'h2);
    evt_lvl <= 1'b0;
    $display("repeat test done");
    // Gated: rise starts, fall pauses; at the end of the auto entry the top level drops back to waiting for a rise
    trig_lvl <= 1'b0;
    wr(`WSC_ADDR_CTRL, 32'(WSC_TRIG_GATED));
    wr(`WSC_ADDR_START, 32'h1);
    wr(`WSC_ADDR_CMD, 32'h1);
    trig_lvl <= 1'b1;
    repeat (6) @(posedge clk_in);
    trig_lvl <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h1f, 32'h10);
    $display("gated test done");
    // Reset in mid-run must drop back to idle programming mode
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1 check({29'h0, running_out, hold_last_out, sample_valid_out}, 32'h0);
    @(posedge clk_in);
    rd(`WSC_ADDR_STATUS, v);
    check(v & 32'h7f, 32'h1);
    $display("mid-run reset test done");
    summarize();
  end
endmodule : waveform_sequencer_control_test

/* tb/wsc_sequencer_chk.sv */
// Port checker for wsc_sequencer, bound at the foot of this file.
// Assumes one clock domain and the register map in wsc_defines.svh.
`timescale 1ns/1ps
`include "wsc_defines.svh"
module wsc_sequencer_chk
  import wsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [`WSC_GRAN*`WSC_ADDR_W-1:0] sample_addr_out,
  input wire logic sample_valid_out,
  input wire logic hold_last_out,
  input wire logic running_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ----
  // Shadow of trigger and arm fields
  // ----
  logic [2:0] ctrl_reg;
  wire logic cmd = reg_wr_in && reg_addr_in == `WSC_ADDR_CMD;
  wire logic run = cmd && reg_wdata_in[`WSC_CMD_RUN_BIT];
  wire logic stop = cmd && reg_wdata_in[`WSC_CMD_STOP_BIT];
  wire logic cont = ctrl_reg == 3'h0;
  wire logic [11:0] lane0 = sample_addr_out[11:0];
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= 3'h0;
    end else if (reg_wr_in && reg_addr_in == `WSC_ADDR_CTRL) begin
      ctrl_reg <= reg_wdata_in[2:0];
    end
  end
  sequence s_go;
    run && cont && !running_out;
  endsequence
  sequence s_play;
    running_out ##1 sample_valid_out;
  endsequence
  AST_IDLE: assert property (!running_out && !run |=> !running_out) else $error("left idle");
  AST_STOP: assert property (stop |=> !running_out) else $error("stop ignored");
  AST_START: assert property (run |=> running_out) else $error("run ignored");
  AST_GO: assert property (s_go |=> s_play) else $error("no play after run");
  AST_CONT: assert property (cont && running_out && sample_valid_out && !stop && !hold_last_out
    |=> sample_valid_out || hold_last_out) else $error("play broke off");
  AST_VALID: assert property (sample_valid_out |-> $past(running_out)) else $error("group while idle");
  AST_LANES: assert property (sample_valid_out |-> sample_addr_out[23:12] == lane0 + 12'h1
    && sample_addr_out[35:24] == lane0 + 12'h2 && sample_addr_out[47:36] == lane0 + 12'h3) else $error("lanes");
  AST_HOLD: assert property (hold_last_out |-> running_out ##1 !sample_valid_out) else $error("hold plays");
endmodule : wsc_sequencer_chk
bind wsc_sequencer wsc_sequencer_chk chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .sample_addr_out(sample_addr_out), .sample_valid_out(sample_valid_out),
  .hold_last_out(hold_last_out), .running_out(running_out));

/* tb/wsc_src_model.sv */
// Far-side source model: trigger, event and enable levels.
// Assumes the bench requests levels; lines move just after a clock edge.
`timescale 1ns/1ps
module wsc_src_model (
  input wire logic clk_in,
  input wire logic trig_req_in,
  input wire logic evt_req_in,
  input wire logic en_req_in,
  output logic trigger_out,
  output logic event_out,
  output logic enable_out
);
  // Launched off the sequencer clock so the block samples it cleanly
  always @(posedge clk_in) begin
    trigger_out <= trig_req_in;
    event_out <= evt_req_in;
    enable_out <= en_req_in;
  end
endmodule : wsc_src_model
